/* File: src/tmr_cfg_pkg.sv */
// constants and carrier types for the timer configuration control block
// assumes a single 125 MHz clock domain and an AHB-Lite register bus
package tmr_cfg_pkg;

  // register byte addresses
  localparam logic [7:0] addr_configuration = 8'h00;
  localparam logic [7:0] addr_control = 8'h04;
  localparam logic [7:0] addr_modulo = 8'h08;
  localparam logic [7:0] addr_status = 8'h0c;

  // configuration field positions
  localparam int trigger_select_lsb = 24;
  localparam int reload_on_trigger_pos = 18;
  localparam int stop_on_overflow_pos = 17;
  localparam int start_on_trigger_pos = 16;
  localparam int global_timebase_pos = 9;
  localparam int debug_behaviour_lsb = 6;
  localparam int doze_pause_pos = 5;

  // writable bits of configuration; reserved bits read zero
  localparam logic [31:0] configuration_mask = 32'h0f07_02e0;
  localparam logic [31:0] configuration_reset = 32'h0000_0000;
  localparam logic [1:0] clock_mode_reset = 2'h0;
  localparam logic [15:0] modulo_reset = 16'hffff;
  localparam logic [1:0] debug_continue = 2'h3;

  // status bit positions
  localparam int status_overflow_pos = 0;
  localparam int status_running_pos = 1;
  localparam int status_halted_pos = 2;

  // run state of the counter
  typedef enum logic [1:0] {
    st_disabled,
    st_wait_trigger,
    st_running,
    st_halted
  } run_state_type;

  // pause and trigger inputs from the system
  typedef struct packed {
    logic debug_active;
    logic doze_active;
    logic trigger_in;
  } sys_in_type;

endpackage : tmr_cfg_pkg

/* File: src/trig_edge.sv */
// rising edge detector behind a two-stage synchroniser
// assumes the input may be asynchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module trig_edge
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } edge_state_type;
  edge_state_type state;
  edge_state_type next_state;

  // only s2 and s3 feed the edge compare
  always_comb
  begin
    next_state = state;
    next_state.s1 = din;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    next_state.rise = state.s2 & ~state.s3;
  end

  // register
  always_ff @(posedge mclk)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign rise = state.rise;
endmodule : trig_edge
`default_nettype wire

/* File: src/timer_counter_config_control.sv */
// timer configuration control: run state, counter, timebase select, AHB-Lite slave
// assumes one clock, synchronous reset, single word AHB-Lite transfers
//
// Functional notes
// - stop-on-overflow set halts counting after overflow; clear keeps counting.
// - start-on-trigger set: enabled counter waits for trigger rising edge.
// - start-on-trigger set: trigger edge restarts a counter halted by overflow.
// - start-on-trigger clear: counter counts right after enabling.
// - trigger ignored while paused by debug or doze.
// - global timebase select set: channels see the external timebase.
// - global timebase select clear: channels see the internal counter.
// - internal counter keeps wrapping and flagging overflow with external timebase.
// - debug pause setting: no counting, no triggers during debug.
// - debug behaviour 11 keeps counting in debug.
// - doze pause clear: counting continues in doze.
// - doze pause set: no counting, no triggers in doze.
// - reserved configuration bits read zero and ignore writes.
// - overflow is an increment at the modulo value; sets the overflow flag.
// - reload to zero by write or trigger is no overflow.
// - clock mode resets to zero so the counter starts disabled.
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module timer_counter_config_control
#(
  parameter int count_width = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tmr_cfg_pkg::sys_in_type sys_in,
  input wire logic [count_width-1:0] global_timebase,
  output logic [count_width-1:0] channel_timebase,
  output logic [count_width-1:0] counter_value,
  output logic overflow_flag,
  output logic counting
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0] configuration;
    logic [1:0] clock_mode_select;
    logic [count_width-1:0] modulo_value;
    logic [count_width-1:0] count;
    logic overflow_flag;
    tmr_cfg_pkg::run_state_type run;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic [count_width-1:0] channel_timebase;
    logic counting;
  } ctl_state_type;

  ctl_state_type state;
  ctl_state_type next_state;
  logic trig_rise;
  logic paused;
  logic trig_ok;
  logic enabled;
  logic at_modulo;
  logic addr_phase;
  logic stop_on_overflow;
  logic start_on_trigger;
  logic reload_on_trigger;
  logic global_timebase_select;
  logic doze_pause;
  logic [1:0] debug_behaviour;
  logic [31:0] read_word;
  logic [31:0] status_word;
  logic overflow_event;

  ////////////////////////////////////////////////////////////////////////
  // trigger edge detection

  trig_edge u_trig_edge
  (
    .mclk(mclk),
    .rst(rst),
    .din(sys_in.trigger_in),
    .rise(trig_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoded configuration fields

  // field extraction
  assign stop_on_overflow = state.configuration[tmr_cfg_pkg::stop_on_overflow_pos];
  assign start_on_trigger = state.configuration[tmr_cfg_pkg::start_on_trigger_pos];
  assign reload_on_trigger = state.configuration[tmr_cfg_pkg::reload_on_trigger_pos];
  assign global_timebase_select = state.configuration[tmr_cfg_pkg::global_timebase_pos];
  assign doze_pause = state.configuration[tmr_cfg_pkg::doze_pause_pos];
  assign debug_behaviour = state.configuration[tmr_cfg_pkg::debug_behaviour_lsb +: 2];

  // pause conditions and trigger gating
  assign paused = (sys_in.debug_active && debug_behaviour != tmr_cfg_pkg::debug_continue)
    || (sys_in.doze_active && doze_pause);
  assign trig_ok = trig_rise && !paused;
  assign enabled = state.clock_mode_select != 2'h0;
  assign at_modulo = state.count == state.modulo_value;
  // overflow in this cycle; beats a software clear of the flag
  assign overflow_event = state.run == tmr_cfg_pkg::st_running && !paused && at_modulo;
  assign addr_phase = hsel && hready && htrans[1];

  // status readback
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[tmr_cfg_pkg::status_overflow_pos] = state.overflow_flag;
    status_word[tmr_cfg_pkg::status_running_pos] = state.run == tmr_cfg_pkg::st_running;
    status_word[tmr_cfg_pkg::status_halted_pos] = state.run == tmr_cfg_pkg::st_halted;
  end

  // read multiplexer
  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (haddr[7:0])
      tmr_cfg_pkg::addr_configuration: read_word = state.configuration;
      tmr_cfg_pkg::addr_control: read_word = {30'h0, state.clock_mode_select};
      tmr_cfg_pkg::addr_modulo: read_word = 32'(state.modulo_value);
      tmr_cfg_pkg::addr_status: read_word = status_word;
      default: read_word = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_state = state;
    // bus address phase
    if (addr_phase)
    begin
      next_state.wr_pend = hwrite;
      next_state.wr_addr = haddr[7:0];
      if (!hwrite)
        next_state.hrdata = read_word;
    end
    else if (hready)
      next_state.wr_pend = 1'b0;
    // run state machine
    unique case (state.run)
      tmr_cfg_pkg::st_disabled:
        if (enabled)
          next_state.run = start_on_trigger ? tmr_cfg_pkg::st_wait_trigger
            : tmr_cfg_pkg::st_running;
      tmr_cfg_pkg::st_wait_trigger:
        if (trig_ok)
          next_state.run = tmr_cfg_pkg::st_running;
      tmr_cfg_pkg::st_halted:
        if (trig_ok && start_on_trigger)
          next_state.run = tmr_cfg_pkg::st_running;
      tmr_cfg_pkg::st_running:
        if (!paused)
        begin
          if (at_modulo)
          begin
            next_state.count = '0;
            next_state.overflow_flag = 1'b1;
            if (stop_on_overflow)
              next_state.run = tmr_cfg_pkg::st_halted;
          end
          else
            next_state.count = state.count + 1'b1;
        end
    endcase
    // reload by trigger does not halt the counter
    if (trig_ok && reload_on_trigger && state.run != tmr_cfg_pkg::st_disabled)
      next_state.count = '0;
    if (!enabled)
      next_state.run = tmr_cfg_pkg::st_disabled;
    // bus data phase write
    if (state.wr_pend && hready)
    begin
      unique case (state.wr_addr)
        tmr_cfg_pkg::addr_configuration:
          next_state.configuration = hwdata & tmr_cfg_pkg::configuration_mask;
        tmr_cfg_pkg::addr_control:
          next_state.clock_mode_select = hwdata[1:0];
        tmr_cfg_pkg::addr_modulo:
          next_state.modulo_value = hwdata[count_width-1:0];
        tmr_cfg_pkg::addr_status:
        begin
          // write one clears, a same-cycle overflow wins
          if (hwdata[tmr_cfg_pkg::status_overflow_pos] && !overflow_event)
            next_state.overflow_flag = 1'b0;
          // any write to status reloads the counter, no overflow
          next_state.count = '0;
        end
        default: ;
      endcase
    end
    // timebase selection for the channels
    next_state.channel_timebase = global_timebase_select ? global_timebase
      : next_state.count;
    next_state.counting = next_state.run == tmr_cfg_pkg::st_running && !paused;
  end

  ////////////////////////////////////////////////////////////////////////
  // register

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= '0;
      state.configuration <= tmr_cfg_pkg::configuration_reset;
      state.clock_mode_select <= tmr_cfg_pkg::clock_mode_reset;
      state.modulo_value <= count_width'(tmr_cfg_pkg::modulo_reset);
      state.run <= tmr_cfg_pkg::st_disabled;
    end
    else
      state <= next_state;
  end

  // outputs
  assign hrdata = state.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign channel_timebase = state.channel_timebase;
  assign counter_value = state.count;
  assign overflow_flag = state.overflow_flag;
  assign counting = state.counting;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  property p_stop_on_overflow;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && !paused && at_modulo && stop_on_overflow
      && enabled && !(state.wr_pend && hready))
    |=> state.run == tmr_cfg_pkg::st_halted;
  endproperty
  a_stop_on_overflow: assert property (p_stop_on_overflow) else $error("no halt at overflow");

  property p_wait_trigger;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_wait_trigger && !trig_ok && !(state.wr_pend && hready))
    |=> $stable(state.count);
  endproperty
  a_wait_trigger: assert property (p_wait_trigger) else $error("counted before trigger");

  property p_restart;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_halted && trig_ok && start_on_trigger && enabled)
    |=> state.run == tmr_cfg_pkg::st_running;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on trigger");

  property p_immediate;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_disabled && enabled && !start_on_trigger)
    |=> state.run == tmr_cfg_pkg::st_running;
  endproperty
  a_immediate: assert property (p_immediate) else $error("no immediate start");

  property p_paused_hold;
    @(posedge mclk) disable iff (rst)
    (paused && enabled && state.run != tmr_cfg_pkg::st_disabled
      && !(state.wr_pend && hready))
    |=> state.run == $past(state.run) && state.count == $past(state.count);
  endproperty
  a_paused_hold: assert property (p_paused_hold) else $error("moved while paused");

  property p_timebase;
    @(posedge mclk) disable iff (rst)
    global_timebase_select ##1 global_timebase_select
    |-> channel_timebase == $past(global_timebase);
  endproperty
  a_timebase: assert property (p_timebase) else $error("wrong channel timebase");

  property p_overflow_flag;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && !paused && at_modulo && enabled)
    |=> overflow_flag && counter_value == '0;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow not flagged");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
    (state.configuration & ~tmr_cfg_pkg::configuration_mask) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_wrap_continue;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && !paused && at_modulo && !stop_on_overflow && enabled)
    |=> state.run == tmr_cfg_pkg::st_running;
  endproperty
  a_wrap_continue: assert property (p_wrap_continue) else $error("halted without stop");

  property p_internal_timebase;
    @(posedge mclk) disable iff (rst)
    !global_timebase_select |=> channel_timebase == counter_value;
  endproperty
  a_internal_timebase: assert property (p_internal_timebase) else $error("not internal");

  property p_paused_stop;
    @(posedge mclk) disable iff (rst)
    ((sys_in.debug_active && debug_behaviour != tmr_cfg_pkg::debug_continue)
      || (sys_in.doze_active && doze_pause))
    |=> !counting;
  endproperty
  a_paused_stop: assert property (p_paused_stop) else $error("counting while paused");

  property p_debug_continue;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && enabled && !(at_modulo && stop_on_overflow)
      && sys_in.debug_active && debug_behaviour == tmr_cfg_pkg::debug_continue
      && !(sys_in.doze_active && doze_pause))
    |=> counting;
  endproperty
  a_debug_continue: assert property (p_debug_continue) else $error("stopped in debug");

  property p_doze_continue;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && enabled && !(at_modulo && stop_on_overflow)
      && sys_in.doze_active && !doze_pause
      && !(sys_in.debug_active && debug_behaviour != tmr_cfg_pkg::debug_continue))
    |=> counting;
  endproperty
  a_doze_continue: assert property (p_doze_continue) else $error("stopped in doze");

  property p_trigger_delay;
    @(posedge mclk) disable iff (rst)
    $rose(sys_in.trigger_in) |-> ##3 trig_rise;
  endproperty
  a_trigger_delay: assert property (p_trigger_delay) else $error("trigger edge lost");

  property p_reload_zero;
    @(posedge mclk) disable iff (rst)
    (state.run == tmr_cfg_pkg::st_running && enabled && trig_ok && reload_on_trigger && !at_modulo)
    |=> state.run == tmr_cfg_pkg::st_running && counter_value == '0;
  endproperty
  a_reload_zero: assert property (p_reload_zero) else $error("reload stopped counter");

  c_overflow_halt: cover property (@(posedge mclk) state.run == tmr_cfg_pkg::st_halted);
  c_trigger_start: cover property (@(posedge mclk)
    state.run == tmr_cfg_pkg::st_wait_trigger ##1 state.run == tmr_cfg_pkg::st_running);
  c_paused: cover property (@(posedge mclk) paused && state.run == tmr_cfg_pkg::st_running);
  c_reload: cover property (@(posedge mclk) trig_ok && reload_on_trigger);

endmodule : timer_counter_config_control
`default_nettype wire

/* File: testbench/trig_src_model.sv */
// partner model: selected trigger source and external global timebase
// assumes the timer's mclk and synchronous active high rst
`timescale 1ns/100ps
`default_nettype none
module trig_src_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [3:0] high_len,
  output logic trigger_out,
  output logic [15:0] timebase
);
  logic [3:0] left;
  ////////////////////////////////////////////////////////////////////////
  // free running shared timebase; trigger held high for high_len cycles
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      left <= 4'h0;
      trigger_out <= 1'b0;
      timebase <= 16'h0000;
    end
    else
    begin
      timebase <= timebase + 16'h0001;
      if (fire)
        left <= high_len;
      else if (left != 4'h0)
        left <= left - 4'h1;
      trigger_out <= fire || (left > 4'h1); // level, bench keeps it low between
    end
  end
endmodule : trig_src_model
`default_nettype wire

/* File: testbench/timer_counter_config_control_tb.sv */
// self-checking bench for the timer configuration control block
// assumes trig_src_model as trigger and timebase source, AHB-Lite master here
`timescale 1ns/100ps
`default_nettype none
module timer_counter_config_control_tb;
  logic mclk, rst, hsel, hwrite, fire, dbg, dz;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] hlen;
  wire logic hreadyout, hresp, trig, overflow_flag, counting;
  wire logic [15:0] gtb, channel_timebase, counter_value;
  wire tmr_cfg_pkg::sys_in_type sys_in;
  int err_total, samples_checked, cycles;
  logic [31:0] tmp;
  assign sys_in = '{debug_active: dbg, doze_active: dz, trigger_in: trig};
  timer_counter_config_control dut_u (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_in(sys_in),
    .global_timebase(gtb), .channel_timebase(channel_timebase),
    .counter_value(counter_value), .overflow_flag(overflow_flag), .counting(counting));
  trig_src_model src_u (.mclk(mclk), .rst(rst), .fire(fire), .high_len(hlen),
    .trigger_out(trig), .timebase(gtb));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang watchdog
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    tmp = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(tmp, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd
  // wait for counting (sel 0) or overflow_flag (sel 1) to reach v
  task automatic wt(input logic sel, input logic v, input int n);
    int i;
    logic s;
    i = 0;
    s = ~v;
    while (i < n && s !== v)
    begin
      @(posedge mclk);
      s = sel ? overflow_flag : counting;
      i++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask : wt
  task automatic pulse();
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask : pulse
  // disable, clear flag and reload count between tests
  task automatic idle(input string s);
    wr(tmr_cfg_pkg::addr_control, 32'h0);
    wr(tmr_cfg_pkg::addr_status, 32'h1);
    $display("test %s done", s);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    chk({31'h0, counting}, 32'h0);
    rd(tmr_cfg_pkg::addr_configuration, 32'h0);
    wr(tmr_cfg_pkg::addr_configuration, 32'hffff_ffff);
    rd(tmr_cfg_pkg::addr_configuration, tmr_cfg_pkg::configuration_mask);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0);
    rd(8'h10, 32'h0);
    idle("regs");
  endtask : t_regs
  task automatic t_free();
    wr(tmr_cfg_pkg::addr_modulo, 32'h3);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    wt(1'b0, 1'b1, 6);
    wt(1'b1, 1'b1, 10);
    chk({31'h0, counter_value <= 16'h3}, 32'h1);
    repeat (6) @(posedge mclk);
    chk({31'h0, counting}, 32'h1);
    idle("free");
  endtask : t_free
  task automatic t_stop();
    wr(tmr_cfg_pkg::addr_configuration, 32'h0003_0000);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    repeat (8) @(posedge mclk);
    chk({31'h0, counting}, 32'h0);
    pulse();
    wt(1'b0, 1'b1, 8);
    wt(1'b1, 1'b1, 10);
    wt(1'b0, 1'b0, 3);
    tmp = {16'h0, counter_value};
    repeat (5) @(posedge mclk);
    chk({16'h0, counter_value}, tmp);
    hlen <= 4'h9;
    pulse();
    wt(1'b0, 1'b1, 8);
    hlen <= 4'h4;
    idle("stop");
  endtask : t_stop
  task automatic t_pause();
    wr(tmr_cfg_pkg::addr_modulo, 32'hffff);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0003_0020);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    dz <= 1'b1;
    pulse();
    repeat (8) @(posedge mclk);
    chk({31'h0, counting}, 32'h0);
    dz <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({31'h0, counting}, 32'h0);
    pulse();
    wt(1'b0, 1'b1, 8);
    wr(tmr_cfg_pkg::addr_status, 32'h1);
    repeat (3) @(posedge mclk);
    chk({30'h0, overflow_flag, counting}, 32'h1);
    dz <= 1'b1;
    wt(1'b0, 1'b0, 4);
    tmp = {16'h0, counter_value};
    repeat (4) @(posedge mclk);
    chk({16'h0, counter_value}, tmp);
    dz <= 1'b0;
    wt(1'b0, 1'b1, 4);
    dbg <= 1'b1;
    wt(1'b0, 1'b0, 4);
    dbg <= 1'b0;
    wr(tmr_cfg_pkg::addr_control, 32'h0);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0000_00c0);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    dbg <= 1'b1;
    dz <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({31'h0, counting}, 32'h1);
    dbg <= 1'b0;
    dz <= 1'b0;
    idle("pause");
  endtask : t_pause
  task automatic t_tbase();
    wr(tmr_cfg_pkg::addr_modulo, 32'h3);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0000_0200);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    @(posedge mclk);
    chk({16'h0, channel_timebase}, {16'h0, gtb - 16'h1});
    wt(1'b1, 1'b1, 10);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0);
    repeat (3) @(posedge mclk);
    chk({16'h0, channel_timebase}, {16'h0, counter_value});
    idle("tbase");
  endtask : t_tbase
  // reload on trigger zeroes a running count without an overflow
  task automatic t_reload();
    wr(tmr_cfg_pkg::addr_modulo, 32'hffff);
    wr(tmr_cfg_pkg::addr_configuration, 32'h0004_0000);
    wr(tmr_cfg_pkg::addr_control, 32'h1);
    repeat (20) @(posedge mclk);
    pulse();
    repeat (6) @(posedge mclk);
    chk({31'h0, counter_value <= 16'h4}, 32'h1);
    chk({30'h0, overflow_flag, counting}, 32'h1);
    idle("reload");
  endtask : t_reload
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst, hsel, hwrite, fire, dbg, dz} = 6'h20;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    hlen = 4'h4;
    {err_total, samples_checked, cycles} = 96'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_free();
    t_stop();
    t_pause();
    t_reload();
    t_tbase();
    results();
  end
endmodule : timer_counter_config_control_tb
`default_nettype wire
